// ===== hw/ivm_pkg.sv
// Purpose: Shared constants and types for the interrupt vector mapper
// Assumes: 200 MHz core_clk, synchronous active-high reset
// Notes: Interrupt numbers are 8 bits, levels are 5 bits (maskable = 1_xxxx)
package ivm_pkg;
    localparam int NSRC = 48;
    localparam logic [7:0] N_COPRO_ABSENT = 8'h07;
    localparam logic [7:0] N_COPRO_ERR = 8'h08;
    localparam logic [7:0] N_EMU_ENTRY = 8'h09;
    localparam logic [7:0] N_STEP_TRACE = 8'h0c;
    localparam logic [7:0] N_TOOL_NMI = 8'h0d;
    localparam logic [7:0] N_UNDEF = 8'h0e;
    localparam logic [7:0] N_PIN_NMI = 8'h0f;
    localparam logic [4:0] LVL_PIN_NMI = 5'h0f;
    localparam logic [7:0] N_MASK_FIRST = 8'h10;
    localparam logic [7:0] N_EXT0 = 8'h10;
    localparam logic [7:0] N_EXT6_CANW = 8'h16;
    localparam logic [7:0] N_DMA0 = 8'h1e;
    localparam logic [7:0] N_DMA1 = 8'h1f;
    localparam logic [7:0] N_DMA234 = 8'h20;
    localparam logic [7:0] N_CAN = 8'h23;
    localparam logic [7:0] N_PG01 = 8'h26;
    localparam logic [7:0] N_PG23 = 8'h27;
    localparam logic [7:0] N_PG47 = 8'h28;
    localparam logic [7:0] N_FRT1_CMP = 8'h2b;
    localparam logic [7:0] N_FRT1_ZERO = 8'h2c;
    localparam logic [7:0] N_FRT2_CMP = 8'h2d;
    localparam logic [7:0] N_FRT2_ZERO = 8'h2e;
    localparam logic [7:0] N_TBT_OVF = 8'h2f;
    localparam logic [7:0] N_FRT0_CMP = 8'h30;
    localparam logic [7:0] N_FRT0_ZERO = 8'h31;
    localparam logic [7:0] N_ADC1 = 8'h33;
    localparam logic [7:0] N_ADC2 = 8'h34;
    localparam logic [7:0] N_PWM_DONE = 8'h35;
    localparam logic [7:0] N_PWM_OVF = 8'h37;
    localparam logic [7:0] N_CAP0 = 8'h39;
    localparam logic [7:0] N_CAP1 = 8'h3a;
    localparam logic [7:0] N_CAP23 = 8'h3b;
    localparam logic [7:0] N_CMP01 = 8'h3c;
    localparam logic [7:0] N_CMP23 = 8'h3d;
    localparam logic [7:0] N_CMP45 = 8'h3e;
    localparam logic [7:0] N_DELAY_BIT = 8'h3f;
    localparam logic [7:0] N_KERNEL0 = 8'h40;
    localparam logic [7:0] N_KERNEL1 = 8'h41;
    localparam logic [7:0] N_SWTRAP_FIRST = 8'h50;
    localparam logic [31:0] LVL_REG_BASE = 32'h0000_0440;
    localparam logic [3:0] LVL_RESET = 4'hf;
    localparam logic [31:0] VEC_TOP_OFS = 32'h0000_03fc;
    localparam logic [31:0] BASE_DEFAULT = 32'h000f_fc00;

    typedef enum logic [2:0] {
        TRAP_COPRO_ABSENT = 3'b000,
        TRAP_COPRO_ERR = 3'b001,
        TRAP_EMU_ENTRY = 3'b010,
        TRAP_STEP = 3'b011,
        TRAP_TOOL_NMI = 3'b100,
        TRAP_UNDEF = 3'b101
    } ivm_trap_t;

    typedef struct packed {
        logic [NSRC-1:0][3:0] lvl;
        logic [3:0] rdata;
        logic vld;
        logic [7:0] num;
        logic [4:0] lev;
        logic [31:0] addr;
        logic vvld;
        logic [31:0] vaddr;
    } ivm_state_t;

    // Slot of a maskable number in the level array
    function automatic int slot(input logic [7:0] n);
        return int'(n) - int'(N_MASK_FIRST);
    endfunction

    function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] n);
        return base + VEC_TOP_OFS - {22'h0, n, 2'b00};
    endfunction
endpackage

// ===== hw/ivm_arb_if.sv
// Purpose: Carries pending requests and levels to the arbiter and the winner back
// Assumes: Purely combinational path
// Notes: Index is the maskable slot, number minus 16
`timescale 1ns/1ps
interface ivm_arb_if;
    logic [ivm_pkg::NSRC-1:0] req;
    logic [ivm_pkg::NSRC-1:0][3:0] lvl;
    logic win_valid;
    logic [5:0] win_idx;
    logic [3:0] win_lvl;
    modport arb (input req, input lvl, output win_valid, output win_idx, output win_lvl);
    modport mapper (output req, output lvl, input win_valid, input win_idx, input win_lvl);
endinterface

// ===== hw/ivm_arbiter.sv
// Purpose: Picks the pending maskable request with the lowest level
// Assumes: Levels of 1111 are disabled
// Notes: No state; downward scan lets the lower index win a tie
`timescale 1ns/1ps
module ivm_arbiter (
    ivm_arb_if.arb a // Request and winner bundle
);
    logic [ivm_pkg::NSRC-1:0] live;

    genvar g;
    generate
        for (g = 0; g < ivm_pkg::NSRC; g++)
        begin : g_live
            assign live[g] = a.req[g] && (a.lvl[g] != ivm_pkg::LVL_RESET);
        end
    endgenerate

    always_comb
    begin
        a.win_valid = 1'b0;
        a.win_idx = 6'h00;
        a.win_lvl = ivm_pkg::LVL_RESET;
        for (int i = ivm_pkg::NSRC - 1; i >= 0; i--)
        begin
            if (live[i] && (!a.win_valid || a.lvl[i] <= a.win_lvl))
            begin
                a.win_valid = 1'b1;
                a.win_idx = 6'(i);
                a.win_lvl = a.lvl[i];
            end
        end
    end
endmodule // ivm_arbiter

// ===== hw/ivm_mapper.sv
// Purpose: Maps traps, pin NMI and peripheral requests to numbers, levels, vectors
// Assumes: Core compares irq_level with its own mask and fetches irq_addr
// Notes: Every output is registered, one cycle after its cause
`timescale 1ns/1ps
module ivm_mapper #(
    parameter bit HAS_CAN = 1'b1 // Variant carries the CAN controller
) (
    input wire logic core_clk, // System clock, 200 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic [31:0] vector_table_base, // Table base from the core
    input wire logic trap_valid, // Core raises an exception this cycle
    input wire ivm_pkg::ivm_trap_t trap_kind, // Which exception
    input wire logic pin_nmi, // Pin non-maskable request level
    input wire logic [7:0] ext_int, // External interrupt inputs 0..7
    input wire logic can_wake, // CAN wake-up request
    input wire logic can_req, // CAN controller request
    input wire logic [4:0] dma_done, // DMA channel end or error
    input wire logic [7:0] pg_req, // Pulse generator channels
    input wire logic [2:0] frt_cmp, // Free-run timer compare clear, per timer
    input wire logic [2:0] frt_zero, // Free-run timer zero detect, per timer
    input wire logic tbt_ovf, // Time-base timer overflow
    input wire logic [1:0] adc_done, // Analog converters 1 and 2
    input wire logic pwm_done, // Width measurement complete
    input wire logic pwm_ovf, // Width measurement overflow
    input wire logic [3:0] cap_req, // Capture channels 0..3
    input wire logic [5:0] cmp_req, // Compare match channels 0..5
    input wire logic delay_bit, // Software delayed interrupt bit
    input wire logic [47:0] other_req, // Remaining sources by slot
    input wire logic lvl_wr, // Level register write strobe
    input wire logic [5:0] lvl_idx, // Level register index
    input wire logic [3:0] lvl_wdata, // Level write data
    output logic [3:0] lvl_rdata, // Level read data, registered
    input wire logic vec_req, // Vector address lookup request
    input wire logic [7:0] vec_num, // Number to look up, 0..255
    output logic vec_valid, // Lookup answer valid
    output logic [31:0] vec_addr_out, // Looked up vector address
    output logic irq_valid, // Request forwarded to the core
    output logic [7:0] irq_num, // Forwarded number
    output logic [4:0] irq_level, // Forwarded level
    output logic [31:0] irq_addr // Vector address of forwarded number
);
    ivm_pkg::ivm_state_t st_r;
    ivm_pkg::ivm_state_t st_nxt;
    ivm_arb_if arb_bus ();

    ivm_arbiter u_arb (
        .a(arb_bus.arb)
    );

    function automatic logic [7:0] trap_number(input ivm_pkg::ivm_trap_t k);
        unique case (k)
            ivm_pkg::TRAP_COPRO_ABSENT: return ivm_pkg::N_COPRO_ABSENT;
            ivm_pkg::TRAP_COPRO_ERR: return ivm_pkg::N_COPRO_ERR;
            ivm_pkg::TRAP_EMU_ENTRY: return ivm_pkg::N_EMU_ENTRY;
            ivm_pkg::TRAP_STEP: return ivm_pkg::N_STEP_TRACE;
            ivm_pkg::TRAP_TOOL_NMI: return ivm_pkg::N_TOOL_NMI;
            ivm_pkg::TRAP_UNDEF: return ivm_pkg::N_UNDEF;
            default: return ivm_pkg::N_UNDEF;
        endcase
    endfunction

    // Fold shared and named sources onto their slots
    always_comb
    begin
        logic [47:0] r;
        r = other_req;
        for (int i = 0; i < 8; i++)
        begin
            r[ivm_pkg::slot(ivm_pkg::N_EXT0) + i] = r[ivm_pkg::slot(ivm_pkg::N_EXT0) + i]
                | ext_int[i];
        end
        r[ivm_pkg::slot(ivm_pkg::N_EXT6_CANW)] |= can_wake & HAS_CAN;
        r[ivm_pkg::slot(ivm_pkg::N_CAN)] |= can_req & HAS_CAN;
        r[ivm_pkg::slot(ivm_pkg::N_DMA0)] |= dma_done[0];
        r[ivm_pkg::slot(ivm_pkg::N_DMA1)] |= dma_done[1];
        r[ivm_pkg::slot(ivm_pkg::N_DMA234)] |= |dma_done[4:2];
        r[ivm_pkg::slot(ivm_pkg::N_PG01)] |= |pg_req[1:0];
        r[ivm_pkg::slot(ivm_pkg::N_PG23)] |= |pg_req[3:2];
        r[ivm_pkg::slot(ivm_pkg::N_PG47)] |= |pg_req[7:4];
        r[ivm_pkg::slot(ivm_pkg::N_FRT0_CMP)] |= frt_cmp[0];
        r[ivm_pkg::slot(ivm_pkg::N_FRT0_ZERO)] |= frt_zero[0];
        r[ivm_pkg::slot(ivm_pkg::N_FRT1_CMP)] |= frt_cmp[1];
        r[ivm_pkg::slot(ivm_pkg::N_FRT1_ZERO)] |= frt_zero[1];
        r[ivm_pkg::slot(ivm_pkg::N_FRT2_CMP)] |= frt_cmp[2];
        r[ivm_pkg::slot(ivm_pkg::N_FRT2_ZERO)] |= frt_zero[2];
        r[ivm_pkg::slot(ivm_pkg::N_TBT_OVF)] |= tbt_ovf;
        r[ivm_pkg::slot(ivm_pkg::N_DELAY_BIT)] |= delay_bit;
        r[ivm_pkg::slot(ivm_pkg::N_ADC1)] |= adc_done[0];
        r[ivm_pkg::slot(ivm_pkg::N_ADC2)] |= adc_done[1];
        r[ivm_pkg::slot(ivm_pkg::N_PWM_DONE)] |= pwm_done;
        r[ivm_pkg::slot(ivm_pkg::N_PWM_OVF)] |= pwm_ovf;
        r[ivm_pkg::slot(ivm_pkg::N_CAP0)] |= cap_req[0];
        r[ivm_pkg::slot(ivm_pkg::N_CAP1)] |= cap_req[1];
        r[ivm_pkg::slot(ivm_pkg::N_CAP23)] |= |cap_req[3:2];
        r[ivm_pkg::slot(ivm_pkg::N_CMP01)] |= |cmp_req[1:0];
        r[ivm_pkg::slot(ivm_pkg::N_CMP23)] |= |cmp_req[3:2];
        r[ivm_pkg::slot(ivm_pkg::N_CMP45)] |= |cmp_req[5:4];
        arb_bus.req = r;
        arb_bus.lvl = st_r.lvl;
    end

    always_comb
    begin
        st_nxt = st_r;
        if (lvl_wr && lvl_idx < 6'(ivm_pkg::NSRC))
        begin
            st_nxt.lvl[lvl_idx] = lvl_wdata;
        end
        st_nxt.rdata = (lvl_idx < 6'(ivm_pkg::NSRC)) ? st_r.lvl[lvl_idx] : 4'h0;
        // Exceptions first, then the pin NMI, then the maskable winner
        st_nxt.vld = 1'b0;
        st_nxt.num = 8'h00;
        st_nxt.lev = 5'h1f;
        if (trap_valid)
        begin
            st_nxt.vld = 1'b1;
            st_nxt.num = trap_number(trap_kind);
            st_nxt.lev = 5'h00;
        end
        else if (pin_nmi)
        begin
            st_nxt.vld = 1'b1;
            st_nxt.num = ivm_pkg::N_PIN_NMI;
            st_nxt.lev = ivm_pkg::LVL_PIN_NMI;
        end
        else if (arb_bus.win_valid)
        begin
            st_nxt.vld = 1'b1;
            st_nxt.num = ivm_pkg::N_MASK_FIRST + {2'b00, arb_bus.win_idx};
            st_nxt.lev = {1'b1, arb_bus.win_lvl};
        end
        st_nxt.addr = ivm_pkg::vec_addr(vector_table_base, st_nxt.num);
        st_nxt.vvld = vec_req;
        st_nxt.vaddr = vec_req ? ivm_pkg::vec_addr(vector_table_base, vec_num) : st_r.vaddr;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.lvl <= {ivm_pkg::NSRC{ivm_pkg::LVL_RESET}};
            st_r.lev <= 5'h1f;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign lvl_rdata = st_r.rdata;
    assign irq_valid = st_r.vld;
    assign irq_num = st_r.num;
    assign irq_level = st_r.lev;
    assign irq_addr = st_r.addr;
    assign vec_valid = st_r.vvld;
    assign vec_addr_out = st_r.vaddr;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    vector_address_a: assert property (vec_req |=> vec_valid
        && vec_addr_out == $past(vector_table_base) + 32'h3fc - {22'h0, $past(vec_num), 2'b00})
        else $error("vector address wrong");
    copro_trap_num_a: assert property (trap_valid
        && trap_kind == ivm_pkg::TRAP_COPRO_ABSENT |=> irq_valid && irq_num == 8'h07)
        else $error("coprocessor trap number wrong");
    undef_trap_num_a: assert property (trap_valid
        && trap_kind == ivm_pkg::TRAP_UNDEF |=> irq_num == 8'h0e)
        else $error("undefined instruction number wrong");
    pin_nmi_fixed_a: assert property (!trap_valid && pin_nmi
        |=> irq_num == 8'h0f && irq_level == 5'h0f) else $error("pin nmi wrong");
    maskable_slot_a: assert property (!trap_valid && !pin_nmi && arb_bus.win_valid
        |=> irq_num == 8'h10 + {2'b00, $past(arb_bus.win_idx)}
        && irq_level == {1'b1, $past(arb_bus.win_lvl)}) else $error("slot mismatch");
    winner_enabled_a: assert property (arb_bus.win_valid
        |-> arb_bus.lvl[arb_bus.win_idx] != ivm_pkg::LVL_RESET && arb_bus.req[arb_bus.win_idx])
        else $error("arbiter picked a disabled source");
    ext_six_a: assert property (!trap_valid && !pin_nmi && other_req == 48'h0
        && ext_int == 8'h40 && st_r.lvl[6] == 4'h0 |=> irq_num == 8'h16)
        else $error("external input 6 number wrong");
    level_reset_a: assert property (@(posedge core_clk) disable iff (1'b0) rst
        |=> st_r.lvl[0] == 4'hf && st_r.lvl[47] == 4'hf && !irq_valid)
        else $error("level reset wrong");
    no_high_num_a: assert property (irq_valid
        |-> irq_num < 8'h40 && irq_level != 5'h1f) else $error("forwarded reserved number");
    can_absent_a: assert property (!HAS_CAN && !other_req[19] && !other_req[6]
        && !ext_int[6] |-> !arb_bus.req[19] && !arb_bus.req[6])
        else $error("CAN raised without controller");

    cover_trap_c: cover property (trap_valid ##1 irq_valid);
    cover_nmi_c: cover property (pin_nmi && !trap_valid ##1 irq_num == 8'h0f);
    cover_tie_c: cover property (arb_bus.req[0] && arb_bus.req[1]
        && st_r.lvl[0] == st_r.lvl[1] && st_r.lvl[0] != 4'hf);
    cover_swtrap_c: cover property (vec_req && vec_num >= 8'h50);
endmodule // ivm_mapper

// ===== testbench/ivm_core_model.sv
// Purpose: Behavioural processor core that takes forwarded requests
// Assumes: Same core_clk and synchronous reset as the mapper
// Notes: Takes a request whose level is below its mask, then fetches the vector word
`timescale 1ns/1ps
module ivm_core_model (
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic irq_valid, // Forwarded request
    input wire logic [4:0] irq_level, // Forwarded level
    input wire logic [31:0] irq_addr, // Vector address of the request
    input wire logic [4:0] mask, // Current interrupt level mask
    output logic accept, // Request taken last edge
    output logic [31:0] fetch_addr // Vector word address fetched
);
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            accept <= 1'b0;
            fetch_addr <= 32'h0;
        end
        else
        begin
            accept <= irq_valid && (irq_level < mask);
            if (irq_valid && (irq_level < mask))
            begin
                fetch_addr <= irq_addr;
            end
        end
    end
endmodule // ivm_core_model

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the interrupt vector mapper
// Assumes: 200 MHz core_clk, synchronous active-high reset held 12 cycles
// Notes: Inputs change 1 ns after the rising edge; outputs are checked one edge later
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] base = 32'h000f_fc00;
    logic trap_valid = 1'b0;
    ivm_pkg::ivm_trap_t trap_kind = ivm_pkg::TRAP_COPRO_ABSENT;
    logic pin_nmi = 1'b0;
    logic [44:0] srcs = 45'h0;
    logic [47:0] other_req = 48'h0;
    logic lvl_wr = 1'b0;
    logic [5:0] lvl_idx = 6'h0;
    logic [3:0] lvl_wdata = 4'h0;
    logic vec_req = 1'b0;
    logic [7:0] vec_num = 8'h0;
    logic [4:0] mask = 5'h0;
    logic [3:0] lvl_rdata;
    logic vec_valid;
    logic [31:0] vec_addr_out;
    logic irq_valid;
    logic [7:0] irq_num;
    logic [4:0] irq_level;
    logic [31:0] irq_addr;
    logic core_accept;
    logic [31:0] core_fetch;
    logic nocan_valid;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    // Number expected for each bit of srcs
    logic [7:0] src_num [45] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
        8'h16, 8'h23, 8'h1e, 8'h1f, 8'h20, 8'h20, 8'h20, 8'h26, 8'h26, 8'h27, 8'h27, 8'h28,
        8'h28, 8'h28, 8'h28, 8'h30, 8'h2b, 8'h2d, 8'h31, 8'h2c, 8'h2e, 8'h2f, 8'h33, 8'h34,
        8'h35, 8'h37, 8'h39, 8'h3a, 8'h3b, 8'h3b, 8'h3c, 8'h3c, 8'h3d, 8'h3d, 8'h3e, 8'h3e,
        8'h3f};

    ivm_mapper u_dut (.core_clk(core_clk), .rst(rst), .vector_table_base(base),
        .trap_valid(trap_valid), .trap_kind(trap_kind), .pin_nmi(pin_nmi),
        .ext_int(srcs[7:0]), .can_wake(srcs[8]), .can_req(srcs[9]), .dma_done(srcs[14:10]),
        .pg_req(srcs[22:15]), .frt_cmp(srcs[25:23]), .frt_zero(srcs[28:26]),
        .tbt_ovf(srcs[29]), .adc_done(srcs[31:30]), .pwm_done(srcs[32]), .pwm_ovf(srcs[33]),
        .cap_req(srcs[37:34]), .cmp_req(srcs[43:38]), .delay_bit(srcs[44]),
        .other_req(other_req), .lvl_wr(lvl_wr), .lvl_idx(lvl_idx), .lvl_wdata(lvl_wdata),
        .lvl_rdata(lvl_rdata), .vec_req(vec_req), .vec_num(vec_num), .vec_valid(vec_valid),
        .vec_addr_out(vec_addr_out), .irq_valid(irq_valid), .irq_num(irq_num),
        .irq_level(irq_level), .irq_addr(irq_addr));

    ivm_core_model u_core (.core_clk(core_clk), .rst(rst), .irq_valid(irq_valid),
        .irq_level(irq_level), .irq_addr(irq_addr), .mask(mask), .accept(core_accept),
        .fetch_addr(core_fetch));

    // Same stimulus, variant without the CAN controller
    ivm_mapper #(.HAS_CAN(1'b0)) u_dut_nocan (.core_clk(core_clk), .rst(rst),
        .vector_table_base(base), .trap_valid(trap_valid), .trap_kind(trap_kind),
        .pin_nmi(pin_nmi), .ext_int(srcs[7:0]), .can_wake(srcs[8]), .can_req(srcs[9]),
        .dma_done(srcs[14:10]), .pg_req(srcs[22:15]), .frt_cmp(srcs[25:23]),
        .frt_zero(srcs[28:26]), .tbt_ovf(srcs[29]), .adc_done(srcs[31:30]),
        .pwm_done(srcs[32]), .pwm_ovf(srcs[33]), .cap_req(srcs[37:34]), .cmp_req(srcs[43:38]),
        .delay_bit(srcs[44]), .other_req(other_req), .lvl_wr(lvl_wr), .lvl_idx(lvl_idx),
        .lvl_wdata(lvl_wdata), .lvl_rdata(), .vec_req(vec_req), .vec_num(vec_num),
        .vec_valid(), .vec_addr_out(), .irq_valid(nocan_valid), .irq_num(), .irq_level(),
        .irq_addr());

    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    function automatic logic [31:0] vaddr(input logic [31:0] b, input logic [7:0] n);
        return b + 32'h0000_03fc - {22'h0, n, 2'b00};
    endfunction

    task automatic set_level(input logic [5:0] idx, input logic [3:0] v);
        lvl_wr = 1'b1;
        lvl_idx = idx;
        lvl_wdata = v;
        tick(1);
        lvl_wr = 1'b0;
        tick(1);
    endtask

    task automatic test_reset_levels;
        check(irq_valid, 1'b0);
        check(irq_level, 5'h1f);
        lvl_idx = 6'h00;
        tick(1);
        check(lvl_rdata, 4'hf);
        set_level(6'h2f, 4'h9);
        tick(1);
        check(lvl_rdata, 4'h9);
        set_level(6'h30, 4'h2);
        tick(1);
        check(lvl_rdata, 4'h0);
        set_level(6'h2f, 4'hf);
        $display("test_reset_levels done");
    endtask

    task automatic test_traps;
        ivm_pkg::ivm_trap_t kinds [6] = '{ivm_pkg::TRAP_COPRO_ABSENT,
            ivm_pkg::TRAP_COPRO_ERR, ivm_pkg::TRAP_EMU_ENTRY, ivm_pkg::TRAP_STEP,
            ivm_pkg::TRAP_TOOL_NMI, ivm_pkg::TRAP_UNDEF};
        logic [7:0] nums [6] = '{8'h07, 8'h08, 8'h09, 8'h0c, 8'h0d, 8'h0e};
        pin_nmi = 1'b1;
        trap_valid = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            trap_kind = kinds[i];
            tick(1);
            check(irq_num, nums[i]);
            check(irq_level, 5'h00);
            check(irq_addr, vaddr(base, nums[i]));
        end
        trap_valid = 1'b0;
        set_level(6'h00, 4'h0);
        srcs = 45'h1;
        tick(1);
        check(irq_num, 8'h0f);
        check(irq_level, 5'h0f);
        pin_nmi = 1'b0;
        srcs = 45'h0;
        set_level(6'h00, 4'hf);
        $display("test_traps done");
    endtask

    task automatic test_map;
        logic [7:0] n;
        logic [3:0] v;
        for (int i = 0; i < 45; i++)
        begin
            n = src_num[i];
            v = 4'(i % 15);
            set_level(6'(n - 8'h10), v);
            srcs = 45'h1 << i;
            tick(1);
            check(irq_num, n);
            check(irq_level, {1'b1, v});
            check(irq_addr, vaddr(base, n));
            check(nocan_valid, (i != 8 && i != 9) ? 1'b1 : 1'b0);
            srcs = 45'h0;
            set_level(6'(n - 8'h10), 4'hf);
        end
        $display("test_map done");
    endtask

    task automatic test_arb;
        set_level(6'h00, 4'h5);
        set_level(6'h01, 4'h5);
        srcs = 45'h3;
        tick(1);
        check(irq_num, 8'h10);
        set_level(6'h00, 4'h6);
        tick(1);
        check(irq_num, 8'h11);
        check(irq_level, 5'h15);
        mask = 5'h15;
        tick(2);
        check(core_accept, 1'b0);
        mask = 5'h16;
        tick(2);
        check(core_accept, 1'b1);
        check(core_fetch, vaddr(base, 8'h11));
        set_level(6'h2f, 4'h0);
        other_req = 48'h8000_0000_0000;
        tick(1);
        check(irq_num, 8'h3f);
        set_level(6'h00, 4'hf);
        set_level(6'h01, 4'hf);
        set_level(6'h2f, 4'hf);
        tick(1);
        check(irq_valid, 1'b0);
        srcs = 45'h0;
        other_req = 48'h0;
        set_level(6'h06, 4'h0);
        srcs = 45'h40;
        tick(1);
        check(irq_num, 8'h16);
        srcs = 45'h0;
        set_level(6'h06, 4'hf);
        $display("test_arb done");
    endtask

    task automatic test_lookup;
        logic [7:0] nums [7] = '{8'h00, 8'h01, 8'h0f, 8'h40, 8'h41, 8'h50, 8'hff};
        vec_req = 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            vec_num = nums[i];
            tick(1);
            check(vec_valid, 1'b1);
            check(vec_addr_out, vaddr(base, nums[i]));
        end
        check(vec_addr_out, 32'h000f_fc00);
        base = 32'h0010_0000;
        vec_num = 8'h01;
        tick(1);
        check(vec_addr_out, 32'h0010_03f8);
        vec_req = 1'b0;
        tick(1);
        check(vec_valid, 1'b0);
        $display("test_lookup done");
    endtask

    task automatic finish_test;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            finish_test();
        end
    end

    initial
    begin
        tick(12);
        rst = 1'b0;
        test_reset_levels();
        test_traps();
        test_map();
        test_arb();
        test_lookup();
        finish_test();
    end
endmodule // tb_top
